// File: srs_pkg.sv
// shared constants, codes and carrier types for the step reference sequencer
package srs_pkg;

  localparam int STEPS = 16;
  localparam int IDX_W = 4;
  localparam int REF_W = 11;
  localparam int DUR_W = 16;
  localparam int FREQ_W = 16;
  localparam int VOLT_W = 16;
  localparam int PROD_W = 27;

  // references are signed permille: 1000 is 100.0 %
  localparam logic signed [REF_W-1:0] REF_MAX = 11'sh3e8;
  localparam logic signed [REF_W-1:0] REF_MIN = -11'sh3e8;
  localparam logic signed [REF_W-1:0] REF_RESET = 11'sh000;
  localparam logic [PROD_W-1:0] PERMILLE_DIV = 27'h00003e8;

  localparam logic [IDX_W-1:0] LAST_STEP = 4'hf;
  localparam logic [IDX_W-1:0] FIRST_STEP = 4'h0;
  localparam logic [DUR_W-1:0] ELAPSED_RESET = 16'h0000;
  localparam logic [FREQ_W-1:0] UPDOWN_STEP = 16'h0001;

  // step time base: durations count tenths of the selected unit
  localparam longint CLK_PERIOD_PS = 5000;
  localparam longint TENTH_SEC_PS = 64'h17_4876_e800;
  localparam int TENTH_SEC_CYCLES = int'(TENTH_SEC_PS / CLK_PERIOD_PS);
  localparam int SEC_PER_HOUR = 3600;
  localparam int TENTHS_SEC_PER_TENTH_HOUR = SEC_PER_HOUR;

  typedef enum logic [1:0] {
    SRS_END_STOP = 2'h0,
    SRS_END_HOLD = 2'h1,
    SRS_END_REPEAT = 2'h2
  } srs_end_mode_t;

  typedef enum logic [2:0] {
    SRS_SRC_STORED = 3'h0,
    SRS_SRC_AIN1 = 3'h1,
    SRS_SRC_AIN2 = 3'h2,
    SRS_SRC_AIN3 = 3'h3,
    SRS_SRC_PULSE = 3'h4,
    SRS_SRC_REGULATOR = 3'h5,
    SRS_SRC_PRESET_UPDOWN = 3'h6
  } srs_src_t;

  typedef enum logic [1:0] {
    SRS_DEST_FREQ = 2'h0,
    SRS_DEST_VOLT = 2'h1,
    SRS_DEST_PID = 2'h2
  } srs_dest_t;

  typedef enum logic [2:0] {
    SRS_IDLE = 3'h1,
    SRS_RUN = 3'h2,
    SRS_HOLD = 3'h4
  } srs_state_t;

  typedef struct packed {
    logic signed [REF_W-1:0] ref_val;
    logic [DUR_W-1:0] run_dur;
    logic [1:0] ramp_sel;
  } srs_step_cfg_t;

  typedef struct packed {
    logic on_stop;
    logic on_power;
  } srs_retain_t;

  typedef struct packed {
    logic [IDX_W-1:0] step;
    logic [DUR_W-1:0] elapsed;
  } srs_pos_t;

  localparam srs_pos_t POS_RESET = '{step: 4'h0, elapsed: 16'h0000};

endpackage : srs_pkg

// File: srs_tick.sv
// time base: one pulse per tenth of a second or per tenth of an hour
`timescale 1ns/1ps
module srs_tick #(
  parameter int TENTH_CYCLES = srs_pkg::TENTH_SEC_CYCLES,
  parameter int HOUR_FACTOR = srs_pkg::TENTHS_SEC_PER_TENTH_HOUR
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clear,
  input wire logic unit_hours,
  output logic tick
);

  localparam int CW = $clog2(TENTH_CYCLES + 1);
  localparam int HW = $clog2(HOUR_FACTOR + 1);

  logic [CW-1:0] cyc_q;
  logic [CW-1:0] cyc_d;
  logic [HW-1:0] hr_q;
  logic [HW-1:0] hr_d;
  logic tick_q;
  logic tick_d;
  logic sec_tick;

  always_comb
  begin
    cyc_d = cyc_q + CW'(1);
    sec_tick = 1'b0;
    hr_d = hr_q;
    if (cyc_q == CW'(TENTH_CYCLES - 1))
    begin
      cyc_d = '0;
      sec_tick = 1'b1;
    end
    if (sec_tick)
    begin
      hr_d = (hr_q == HW'(HOUR_FACTOR - 1)) ? '0 : hr_q + HW'(1);
    end
    // restart the phase so a resumed step never loses or gains a partial tenth
    if (clear)
    begin
      cyc_d = '0;
      hr_d = '0;
    end
    tick_d = !clear && sec_tick && (!unit_hours || hr_q == HW'(HOUR_FACTOR - 1));
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cyc_q <= '0;
      hr_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cyc_q <= cyc_d;
      hr_q <= hr_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule : srs_tick

// File: srs_sequencer.sv
// step reference sequencer: sixteen relative references played as a timed sequence
`timescale 1ns/1ps
module srs_sequencer #(
  parameter int TENTH_CYCLES = srs_pkg::TENTH_SEC_CYCLES,
  parameter int HOUR_FACTOR = srs_pkg::TENTHS_SEC_PER_TENTH_HOUR,
  parameter int STEPS = srs_pkg::STEPS
) (
  input wire logic clock,
  input wire logic rstn,
  input srs_pkg::srs_step_cfg_t step_cfg [STEPS],
  input wire logic [1:0] sequence_end_mode,
  input srs_pkg::srs_retain_t sequence_retention_select,
  input wire logic step_time_unit,
  input wire logic [2:0] reference0_source_select,
  input wire logic [1:0] setpoint_dest,
  input wire logic sequence_enable,
  input wire logic signed [srs_pkg::REF_W-1:0] analogue_input_one,
  input wire logic signed [srs_pkg::REF_W-1:0] analogue_input_two,
  input wire logic signed [srs_pkg::REF_W-1:0] analogue_input_three,
  input wire logic signed [srs_pkg::REF_W-1:0] pulse_input_ref,
  input wire logic signed [srs_pkg::REF_W-1:0] regulator_output_ref,
  input wire logic [srs_pkg::FREQ_W-1:0] preset_frequency,
  input wire logic [srs_pkg::FREQ_W-1:0] max_frequency,
  input wire logic [srs_pkg::VOLT_W-1:0] rated_motor_voltage,
  input wire logic [srs_pkg::IDX_W-1:0] digital_input_terminal,
  input wire logic up_terminal,
  input wire logic down_terminal,
  input wire logic run_start,
  input wire logic stop_cmd,
  input srs_pkg::srs_pos_t saved_pos,
  output logic [srs_pkg::FREQ_W-1:0] freq_setpoint,
  output logic reverse,
  output logic [srs_pkg::VOLT_W-1:0] volt_setpoint,
  output logic signed [srs_pkg::REF_W-1:0] pid_setpoint,
  output logic [1:0] ramp_set,
  output logic [srs_pkg::IDX_W-1:0] active_index,
  output logic running,
  output logic cycle_done,
  output srs_pkg::srs_pos_t live_pos
);

  localparam int IW = srs_pkg::IDX_W;
  localparam int RW = srs_pkg::REF_W;
  localparam int FW = srs_pkg::FREQ_W;
  localparam int PW = srs_pkg::PROD_W;

  // ---------------- pin synchronisers and up/down edges
  logic [IW+1:0] pin_meta_q;
  logic [IW+1:0] pin_sync_q;
  logic [1:0] ud_prev_q;
  logic [IW-1:0] di_idx;
  logic up_edge;
  logic down_edge;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      ud_prev_q <= '0;
    end
    else
    begin
      pin_meta_q <= {up_terminal, down_terminal, digital_input_terminal};
      pin_sync_q <= pin_meta_q;
      ud_prev_q <= pin_sync_q[IW+1:IW];
    end
  end

  assign di_idx = pin_sync_q[IW-1:0];
  assign up_edge = pin_sync_q[IW+1] && !ud_prev_q[1];
  assign down_edge = pin_sync_q[IW] && !ud_prev_q[0];

  // ---------------- reference clamping, one per step
  logic signed [RW-1:0] ref_clamped [STEPS];

  genvar g;
  generate
    for (g = 0; g < STEPS; g++)
    begin : g_clamp
      assign ref_clamped[g] = (step_cfg[g].ref_val > srs_pkg::REF_MAX) ? srs_pkg::REF_MAX :
                              (step_cfg[g].ref_val < srs_pkg::REF_MIN) ? srs_pkg::REF_MIN :
                              step_cfg[g].ref_val;
    end
  endgenerate

  // ---------------- preset frequency with up/down trim
  logic signed [FW:0] trim_q;
  logic signed [FW:0] trim_d;
  logic [FW+1:0] preset_sum;
  logic [FW-1:0] preset_adj;

  always_comb
  begin
    trim_d = trim_q;
    if (up_edge && !down_edge)
    begin
      trim_d = trim_q + $signed({1'b0, srs_pkg::UPDOWN_STEP});
    end
    else if (down_edge && !up_edge)
    begin
      trim_d = trim_q - $signed({1'b0, srs_pkg::UPDOWN_STEP});
    end
    // keep the trim within plus or minus max_frequency, so it cannot wind up without limit
    if (trim_d > $signed({1'b0, max_frequency}))
    begin
      trim_d = $signed({1'b0, max_frequency});
    end
    else if (trim_d < -$signed({1'b0, max_frequency}))
    begin
      trim_d = -$signed({1'b0, max_frequency});
    end
    preset_sum = FW'(0) + (FW+2)'($signed({2'b00, preset_frequency}) + (FW+2)'(trim_q));
    if (preset_sum[FW+1])
    begin
      preset_adj = '0;
    end
    else if (preset_sum[FW:0] > {1'b0, max_frequency})
    begin
      preset_adj = max_frequency;
    end
    else
    begin
      preset_adj = preset_sum[FW-1:0];
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      trim_q <= '0;
    end
    else
    begin
      trim_q <= trim_d;
    end
  end

  // ---------------- step time base
  logic tick;

  srs_tick #(
    .TENTH_CYCLES(TENTH_CYCLES),
    .HOUR_FACTOR(HOUR_FACTOR)
  ) u_tick (
    .clock(clock),
    .rstn(rstn),
    .clear(run_start),
    .unit_hours(step_time_unit),
    .tick(tick)
  );

  // ---------------- sequence state machine
  srs_pkg::srs_state_t state_q;
  srs_pkg::srs_state_t state_d;
  srs_pkg::srs_pos_t pos_q;
  srs_pkg::srs_pos_t pos_d;
  logic powerup_q;
  logic powerup_d;
  logic done_q;
  logic done_d;
  logic step_over;

  always_comb
  begin
    state_d = state_q;
    pos_d = pos_q;
    powerup_d = powerup_q;
    done_d = 1'b0;
    step_over = pos_q.elapsed >= step_cfg[pos_q.step].run_dur;
    unique case (state_q)
      srs_pkg::SRS_IDLE:
      begin
        if (run_start)
        begin
          state_d = srs_pkg::SRS_RUN;
          powerup_d = 1'b0;
          if (powerup_q)
          begin
            pos_d = sequence_retention_select.on_power ? saved_pos : srs_pkg::POS_RESET;
          end
          else if (!sequence_retention_select.on_stop)
          begin
            pos_d = srs_pkg::POS_RESET;
          end
        end
      end
      srs_pkg::SRS_RUN:
      begin
        if (stop_cmd)
        begin
          state_d = srs_pkg::SRS_IDLE;
        end
        else if (step_over && pos_q.step == srs_pkg::LAST_STEP)
        begin
          done_d = 1'b1;
          if (sequence_end_mode == srs_pkg::SRS_END_HOLD)
          begin
            state_d = srs_pkg::SRS_HOLD;
          end
          else if (sequence_end_mode == srs_pkg::SRS_END_REPEAT)
          begin
            pos_d = srs_pkg::POS_RESET;
          end
          else
          begin
            // unused code 3 behaves as stop
            state_d = srs_pkg::SRS_IDLE;
            pos_d = srs_pkg::POS_RESET;
          end
        end
        else if (step_over)
        begin
          pos_d.step = pos_q.step + IW'(1);
          pos_d.elapsed = srs_pkg::ELAPSED_RESET;
        end
        else if (tick)
        begin
          pos_d.elapsed = pos_q.elapsed + srs_pkg::DUR_W'(1);
        end
      end
      srs_pkg::SRS_HOLD:
      begin
        if (stop_cmd)
        begin
          state_d = srs_pkg::SRS_IDLE;
        end
      end
      default:
      begin
        state_d = srs_pkg::SRS_IDLE;
        pos_d = srs_pkg::POS_RESET;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= srs_pkg::SRS_IDLE;
      pos_q <= srs_pkg::POS_RESET;
      powerup_q <= 1'b1;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pos_q <= pos_d;
      powerup_q <= powerup_d;
      done_q <= done_d;
    end
  end

  // ---------------- setpoint output stage
  logic [FW-1:0] freq_q;
  logic [FW-1:0] freq_d;
  logic rev_q;
  logic rev_d;
  logic [srs_pkg::VOLT_W-1:0] volt_q;
  logic [srs_pkg::VOLT_W-1:0] volt_d;
  logic signed [RW-1:0] pid_q;
  logic signed [RW-1:0] pid_d;
  logic [1:0] ramp_q;
  logic [1:0] ramp_d;
  logic [IW-1:0] idx_q;
  logic [IW-1:0] idx_d;
  logic run_q;
  logic run_d;
  logic signed [RW-1:0] sel_ref;
  logic [RW-2:0] sel_mag;
  logic [PW-1:0] freq_prod;
  logic [PW-1:0] volt_prod;
  logic use_preset;

  always_comb
  begin
    idx_d = sequence_enable ? pos_q.step : di_idx;
    run_d = sequence_enable ? (state_q != srs_pkg::SRS_IDLE) : 1'b1;
    use_preset = 1'b0;
    sel_ref = ref_clamped[idx_d];
    if (idx_d == srs_pkg::FIRST_STEP)
    begin
      unique case (reference0_source_select)
        srs_pkg::SRS_SRC_AIN1: sel_ref = analogue_input_one;
        srs_pkg::SRS_SRC_AIN2: sel_ref = analogue_input_two;
        srs_pkg::SRS_SRC_AIN3: sel_ref = analogue_input_three;
        srs_pkg::SRS_SRC_PULSE: sel_ref = pulse_input_ref;
        srs_pkg::SRS_SRC_REGULATOR: sel_ref = regulator_output_ref;
        srs_pkg::SRS_SRC_PRESET_UPDOWN:
        begin
          sel_ref = srs_pkg::REF_RESET;
          use_preset = 1'b1;
        end
        default: sel_ref = ref_clamped[0];
      endcase
      // outside sources are bounded the same way as stored values
      if (sel_ref > srs_pkg::REF_MAX)
      begin
        sel_ref = srs_pkg::REF_MAX;
      end
      else if (sel_ref < srs_pkg::REF_MIN)
      begin
        sel_ref = srs_pkg::REF_MIN;
      end
    end
    // magnitude is at most 1000 after the clamp, so it fits one bit narrower
    sel_mag = sel_ref[RW-1] ? (RW-1)'(-sel_ref) : sel_ref[RW-2:0];
    freq_prod = PW'(sel_mag) * PW'(max_frequency);
    volt_prod = PW'(sel_mag) * PW'(rated_motor_voltage);
    freq_d = use_preset ? preset_adj : FW'(freq_prod / srs_pkg::PERMILLE_DIV);
    rev_d = sel_ref[RW-1];
    volt_d = srs_pkg::VOLT_W'(volt_prod / srs_pkg::PERMILLE_DIV);
    pid_d = sel_ref;
    ramp_d = step_cfg[idx_d].ramp_sel;
    // one destination at a time; the unused setpoints rest at zero
    unique case (setpoint_dest)
      srs_pkg::SRS_DEST_FREQ:
      begin
        volt_d = '0;
        pid_d = '0;
      end
      srs_pkg::SRS_DEST_VOLT:
      begin
        freq_d = '0;
        rev_d = 1'b0;
        pid_d = '0;
      end
      default:
      begin
        freq_d = '0;
        rev_d = 1'b0;
        volt_d = '0;
      end
    endcase
    if (!run_d)
    begin
      freq_d = '0;
      volt_d = '0;
      rev_d = rev_q;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      freq_q <= '0;
      rev_q <= 1'b0;
      volt_q <= '0;
      pid_q <= srs_pkg::REF_RESET;
      ramp_q <= '0;
      idx_q <= '0;
      run_q <= 1'b0;
    end
    else
    begin
      freq_q <= freq_d;
      rev_q <= rev_d;
      volt_q <= volt_d;
      pid_q <= pid_d;
      ramp_q <= ramp_d;
      idx_q <= idx_d;
      run_q <= run_d;
    end
  end

  assign freq_setpoint = freq_q;
  assign reverse = rev_q;
  assign volt_setpoint = volt_q;
  assign pid_setpoint = pid_q;
  assign ramp_set = ramp_q;
  assign active_index = idx_q;
  assign running = run_q;
  assign cycle_done = done_q;
  assign live_pos = pos_q;

endmodule : srs_sequencer

// File: srs_drive_model.sv
// drive side model: run and stop command pulses and digital input terminal levels
`timescale 1ns/1ps
module srs_drive_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic [3:0] di_val,
  output logic run_start,
  output logic stop_cmd,
  output logic [3:0] digital_input_terminal
);
  // commands leave one edge after the request and last one cycle
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      run_start <= 1'b0;
      stop_cmd <= 1'b0;
    end
    else
    begin
      run_start <= start_req && !run_start;
      stop_cmd <= stop_req && !stop_cmd;
    end
  end
  // terminal levels always driven, they pick the reference index while sequence_enable is low
  assign digital_input_terminal = di_val;
endmodule : srs_drive_model

// File: srs_sequencer_asserts.sv
// checker for scaling, direction, ramp and end-of-cycle behaviour
`timescale 1ns/1ps
module srs_sequencer_asserts #(
  parameter int STEPS = srs_pkg::STEPS
) (
  input wire logic clock,
  input wire logic rstn,
  input srs_pkg::srs_step_cfg_t step_cfg [STEPS],
  input wire logic [1:0] sequence_end_mode,
  input wire logic [1:0] setpoint_dest,
  input wire logic sequence_enable,
  input wire logic [srs_pkg::FREQ_W-1:0] max_frequency,
  input wire logic [srs_pkg::VOLT_W-1:0] rated_motor_voltage,
  input wire logic [srs_pkg::FREQ_W-1:0] freq_setpoint,
  input wire logic reverse,
  input wire logic [srs_pkg::VOLT_W-1:0] volt_setpoint,
  input wire logic signed [srs_pkg::REF_W-1:0] pid_setpoint,
  input wire logic [1:0] ramp_set,
  input wire logic [srs_pkg::IDX_W-1:0] active_index,
  input wire logic running,
  input wire logic cycle_done
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  logic signed [srs_pkg::REF_W-1:0] cur;
  logic [srs_pkg::PROD_W-1:0] mag;
  assign cur = step_cfg[active_index].ref_val;
  assign mag = srs_pkg::PROD_W'(cur < 0 ? -cur : cur);
  // outputs are registered in the same stage as the index; values are judged once settled
  sequence s_steady;
    ($stable(active_index) && $stable(setpoint_dest) && running) [*3];
  endsequence
  sequence s_val;
    s_steady ##0 (active_index != srs_pkg::FIRST_STEP);
  endsequence
  AST_FREQ: assert property (s_val ##0 setpoint_dest == srs_pkg::SRS_DEST_FREQ |->
    freq_setpoint == 16'(mag * max_frequency / srs_pkg::PERMILLE_DIV))
    else $error("frequency setpoint not scaled from reference");
  AST_VOLT: assert property (s_val ##0 setpoint_dest == srs_pkg::SRS_DEST_VOLT |->
    volt_setpoint == 16'(mag * rated_motor_voltage / srs_pkg::PERMILLE_DIV))
    else $error("voltage setpoint not scaled from reference");
  AST_PID: assert property (s_val ##0 setpoint_dest >= 2'h2 |-> pid_setpoint == cur)
    else $error("regulator setpoint differs from reference");
  AST_DIR: assert property (s_val ##0 setpoint_dest == 2'h0 |-> reverse == (cur < 0))
    else $error("direction does not follow reference sign");
  AST_RAMP: assert property (s_steady |-> ramp_set == step_cfg[active_index].ramp_sel)
    else $error("ramp set differs from step selector");
  AST_ADVANCE: assert property ($changed(active_index) && sequence_enable &&
    $past(sequence_enable) && $past(running) |-> active_index == $past(active_index) + 4'h1)
    else $error("step did not advance to next index");
  AST_END_STOP: assert property (cycle_done && sequence_end_mode == 2'h0 |->
    ##[0:2] (!running) [*4])
    else $error("drive not stopped after cycle");
  AST_END_HOLD: assert property (cycle_done && sequence_end_mode == 2'h1 |->
    (running && active_index == srs_pkg::LAST_STEP) [*4])
    else $error("last step not held after cycle");
  AST_END_REPEAT: assert property (cycle_done && sequence_end_mode == 2'h2 |->
    ##[0:2] (running && active_index == srs_pkg::FIRST_STEP))
    else $error("sequence did not restart at first step");
endmodule : srs_sequencer_asserts

// File: srs_sequencer_tb.sv
// testbench for the step reference sequencer
`timescale 1ns/1ps
module srs_sequencer_tb;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  srs_pkg::srs_step_cfg_t step_cfg [srs_pkg::STEPS];
  logic [1:0] sequence_end_mode = 2'h2;
  srs_pkg::srs_retain_t sequence_retention_select = 2'h2;
  logic step_time_unit = 1'b0;
  logic [2:0] reference0_source_select = 3'h0;
  logic [1:0] setpoint_dest = 2'h0;
  logic sequence_enable = 1'b0;
  logic signed [10:0] ain [5];
  logic [15:0] preset_frequency = 16'h012c;
  logic [15:0] max_frequency = 16'h03e8;
  logic [15:0] rated_motor_voltage = 16'h07d0;
  logic up_terminal = 1'b0;
  logic down_terminal = 1'b0;
  logic start_req = 1'b0;
  logic stop_req = 1'b0;
  logic [3:0] di_val = 4'h0;
  srs_pkg::srs_pos_t saved_pos = srs_pkg::POS_RESET;
  logic [3:0] digital_input_terminal;
  logic run_start;
  logic stop_cmd;
  logic [15:0] freq_setpoint;
  logic reverse;
  logic [15:0] volt_setpoint;
  logic signed [10:0] pid_setpoint;
  logic [1:0] ramp_set;
  logic [3:0] active_index;
  logic running;
  logic cycle_done;
  srs_pkg::srs_pos_t live_pos;
  int mismatches = 0;
  int checks_done = 0;
  int seed = 91;
  logic [3:0] exp_q [$];
  logic [3:0] prev_idx = 4'h0;

  initial
  begin
    forever #2.5 clock = ~clock;
  end

  srs_drive_model u_drive (.clock, .rstn, .start_req, .stop_req, .di_val, .run_start,
    .stop_cmd, .digital_input_terminal);
  srs_sequencer #(.TENTH_CYCLES(4), .HOUR_FACTOR(3)) uut (.clock, .rstn, .step_cfg,
    .sequence_end_mode, .sequence_retention_select, .step_time_unit,
    .reference0_source_select, .setpoint_dest, .sequence_enable,
    .analogue_input_one(ain[0]), .analogue_input_two(ain[1]), .analogue_input_three(ain[2]),
    .pulse_input_ref(ain[3]), .regulator_output_ref(ain[4]), .preset_frequency,
    .max_frequency, .rated_motor_voltage, .digital_input_terminal, .up_terminal,
    .down_terminal, .run_start, .stop_cmd, .saved_pos, .freq_setpoint, .reverse,
    .volt_setpoint, .pid_setpoint, .ramp_set, .active_index, .running, .cycle_done,
    .live_pos);

  task automatic report_and_stop();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_idx(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t index got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_idx

  // every index change must match the oldest expected step
  always @(posedge clock)
  begin
    if (rstn && active_index !== prev_idx)
      cmp_idx(active_index, exp_q.size() > 0 ? exp_q.pop_front() : ~active_index);
    prev_idx <= active_index;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task automatic cmd(input logic go);
    start_req <= go;
    stop_req <= !go;
    @(posedge clock);
    start_req <= 1'b0;
    stop_req <= 1'b0;
  endtask : cmd

  task automatic push(input int lo, input int hi);
    for (int i = lo; i <= hi; i++)
      exp_q.push_back(4'(i));
  endtask : push

  task automatic wait_for(input logic use_done, input logic [3:0] v);
    int n;
    n = 0;
    while ((use_done ? cycle_done !== 1'b1 : active_index !== v) && n < 3000)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 3000)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask : wait_for

  initial
  begin
    logic [3:0] nxt;
    logic signed [10:0] r;
    // regulator input sits beyond full scale so the clamp is exercised
    for (int i = 0; i < 5; i++)
      ain[i] <= 11'((i == 4) ? 1020 : 101 * (i + 1) * ((i % 2) ? -1 : 1));
    // zero durations included: those steps last a single cycle
    // step 5 runs long so the stop request lands while it is still active
    for (int i = 0; i < srs_pkg::STEPS; i++)
      step_cfg[i] <= '{11'($random(seed) % 1001),
        (i == 5) ? 16'h0008 : 16'($unsigned($random(seed)) % 4),
        2'($random(seed))};
    tick(12);
    rstn <= 1'b1;
    tick(2);
    for (int d = 0; d < 3; d++)
      for (int k = 0; k < 5; k++)
      begin
        nxt = 4'(1 + $unsigned($random(seed)) % 15);
        if (nxt != di_val)
          exp_q.push_back(nxt);
        setpoint_dest <= 2'(d);
        di_val <= nxt;
        tick(8);
        r = step_cfg[nxt].ref_val;
        if (d == 0)
          cmp_val(freq_setpoint, 16'(r < 0 ? -r : r));
        if (d == 0)
          cmp_val(16'(reverse), 16'(r < 0));
        if (d == 1)
          cmp_val(volt_setpoint, 16'(2 * (r < 0 ? -r : r)));
        if (d == 2)
          cmp_val(16'(pid_setpoint), 16'(r));
        cmp_val(16'(ramp_set), 16'(step_cfg[nxt].ramp_sel));
      end
    exp_q.push_back(4'h0);
    di_val <= 4'h0;
    setpoint_dest <= 2'h0;
    for (int s = 0; s < 6; s++)
    begin
      reference0_source_select <= 3'(s);
      tick(8);
      r = (s == 0) ? step_cfg[0].ref_val : ain[(s + 4) % 5];
      if (r > 11'sh3e8)
        r = 11'sh3e8;
      cmp_val(freq_setpoint, 16'(r < 0 ? -r : r));
    end
    cmp_val(freq_setpoint, 16'h03e8);
    reference0_source_select <= 3'h6;
    repeat (2)
    begin
      up_terminal <= 1'b1;
      tick(3);
      up_terminal <= 1'b0;
      tick(3);
    end
    tick(6);
    cmp_val(freq_setpoint, preset_frequency + 16'h0002);
    down_terminal <= 1'b1;
    tick(3);
    down_terminal <= 1'b0;
    tick(8);
    cmp_val(freq_setpoint, preset_frequency + 16'h0001);
    reference0_source_select <= 3'h0;
    sequence_enable <= 1'b1;
    tick(4);
    push(1, 15);
    push(0, 5);
    cmd(1'b1);
    wait_for(1'b1, 4'h0);
    wait_for(1'b0, 4'h5);
    cmd(1'b0);
    tick(6);
    cmp_val(16'(live_pos.step), 16'h0005);
    sequence_end_mode <= 2'h0;
    setpoint_dest <= 2'h1;
    push(6, 15);
    push(0, 0);
    cmd(1'b1);
    wait_for(1'b1, 4'h0);
    tick(6);
    cmp_val(16'(running), 16'h0000);
    sequence_end_mode <= 2'h1;
    setpoint_dest <= 2'h2;
    step_time_unit <= 1'b1;
    push(1, 15);
    cmd(1'b1);
    wait_for(1'b1, 4'h0);
    tick(20);
    cmp_val(16'(running), 16'h0001);
    cmp_val(16'(active_index), 16'h000f);
    cmd(1'b0);
    tick(4);
    rstn <= 1'b0;
    sequence_retention_select <= 2'h1;
    saved_pos <= '{step: 4'h9, elapsed: 16'h0000};
    sequence_end_mode <= 2'h0;
    setpoint_dest <= 2'h0;
    step_time_unit <= 1'b0;
    tick(12);
    rstn <= 1'b1;
    tick(2);
    push(9, 15);
    push(0, 0);
    cmd(1'b1);
    wait_for(1'b1, 4'h0);
    tick(6);
    cmp_val(16'(exp_q.size()), 16'h0000);
    report_and_stop();
  end
endmodule : srs_sequencer_tb

bind srs_sequencer srs_sequencer_asserts #(.STEPS(STEPS)) u_chk (.clock, .rstn, .step_cfg,
  .sequence_end_mode, .setpoint_dest, .sequence_enable, .max_frequency,
  .rated_motor_voltage, .freq_setpoint, .reverse, .volt_setpoint, .pid_setpoint,
  .ramp_set, .active_index, .running, .cycle_done);
